// ==== acw_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// decoder and acknowledge checks
// ****
module acw_checker (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oen_n,
    input wire logic [2:0] o_ref_sel,
    input wire logic o_bipolar,
    input wire logic [3:0] o_chan_code,
    input wire logic o_single_ended,
    input wire logic [11:0] o_pos_input,
    input wire logic [11:0] o_neg_input,
    input wire logic o_code_reserved,
    input wire logic o_pin_excluded,
    input wire logic o_hs_mode
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_ack_drives_low: assert property (!o_sda_oen_n |-> !o_sda_out)
        else $error("ack drives sda high");
    a_ack_whole_clock: assert property ($rose(o_sda_oen_n) |-> !i_scl && !$past(o_sda_oen_n, 12))
        else $error("ack too short");
    a_single_unipolar: assert property (o_single_ended |-> !o_bipolar)
        else $error("bipolar in single-ended");
    a_reserved_flag: assert property (o_code_reserved == (o_chan_code > 4'hb))
        else $error("reserved flag wrong");
    a_reserved_none: assert property (o_code_reserved |-> (o_pos_input | o_neg_input) == 12'h000)
        else $error("reserved code selects input");
    a_single_select: assert property (o_single_ended && !o_code_reserved && !o_pin_excluded |->
        o_pos_input == (12'h001 << o_chan_code) && o_neg_input == 12'h000)
        else $error("single-ended select wrong");
    a_diff_pair: assert property (!o_single_ended && !o_code_reserved |->
        o_pos_input == (12'h001 << o_chan_code) && o_neg_input == (12'h001 << (o_chan_code ^ 4'h1)))
        else $error("differential pair wrong");
    a_shared_excluded: assert property (o_ref_sel[1] && o_single_ended && o_chan_code == 4'hb |->
        o_pin_excluded && o_pos_input == 12'h000)
        else $error("shared pin not excluded");
    a_stop_leaves_hs: assert property (i_scl && $rose(i_sda) |-> ##[1:8] !o_hs_mode)
        else $error("high-speed kept after stop");
    a_idle_hold: assert property ((i_scl && i_sda) [*8] |=> $stable(o_ref_sel) && $stable(o_chan_code))
        else $error("settings moved while idle");
endmodule
bind acw_config_write acw_checker i_acw_checker (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oen_n(o_sda_oen_n),
    .o_ref_sel(o_ref_sel), .o_bipolar(o_bipolar), .o_chan_code(o_chan_code),
    .o_single_ended(o_single_ended), .o_pos_input(o_pos_input), .o_neg_input(o_neg_input),
    .o_code_reserved(o_code_reserved), .o_pin_excluded(o_pin_excluded), .o_hs_mode(o_hs_mode));
`default_nettype wire

// ==== acw_config_write.v ====
`timescale 1ns/100ps
`default_nettype none
`include "acw_defines.vh"
module acw_config_write #(
    parameter [6:0] DEV_ADDR = 7'h2a, // arbitrary value
    parameter [1:0] CHAN_VARIANT = 2'd2 // 0: four, 1: eight, 2: twelve inputs
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_out,
    output reg o_sda_oen_n,
    output reg [2:0] o_ref_sel,
    output reg o_clk_external,
    output reg o_bipolar,
    output reg [1:0] o_sweep_sel,
    output reg [3:0] o_chan_code,
    output reg o_single_ended,
    output reg [11:0] o_pos_input,
    output reg [11:0] o_neg_input,
    output reg o_neg_is_gnd,
    output reg o_code_reserved,
    output reg o_pin_excluded,
    output reg [3:0] o_scan_limit,
    output reg o_hs_mode
);
    // ****************************************
    // pin sampling and condition detection
    // ****************************************
    wire [1:0] pins_sync;
    acw_sync2 #(.WIDTH(2)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_sync)
    );
    wire scl = pins_sync[1];
    wire sda = pins_sync[0];
    reg scl_d_reg;
    reg sda_d_reg;
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
        end
    end
    wire scl_rise = scl & ~scl_d_reg;
    wire scl_fall = ~scl & scl_d_reg;
    wire start_cond = scl & scl_d_reg & sda_d_reg & ~sda;
    wire stop_cond = scl & scl_d_reg & ~sda_d_reg & sda;

    // ****************************************
    // byte receiver state machine
    // ****************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_DACK = 3'd4;
    localparam ST_HNAK = 3'd5;

    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg ack_hold_reg;
    reg [7:0] setup_byte_reg;
    reg [7:0] configuration_byte_reg;
    wire [7:0] byte_next = {shift_reg[6:0], sda};

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_hold_reg <= 1'b0;
            o_sda_out <= 1'b1;
            o_sda_oen_n <= 1'b1;
            o_hs_mode <= 1'b0;
            setup_byte_reg <= `ACW_SETUP_RESET;
            configuration_byte_reg <= `ACW_CONFIG_RESET;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            o_sda_oen_n <= 1'b1;
            ack_hold_reg <= 1'b0;
            o_hs_mode <= 1'b0; // RULE_07
        end else if (start_cond) begin
            // repeated start keeps the bus mode
            state_reg <= ST_ADDR; // RULE_06
            bit_cnt_reg <= 4'h0;
            o_sda_oen_n <= 1'b1;
            ack_hold_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    o_sda_oen_n <= 1'b1;
                end
                ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        shift_reg <= byte_next;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7) begin
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (byte_next[7:3] == `ACW_HS_CODE) begin
                                    state_reg <= ST_HNAK;
                                end else if (byte_next[7:1] == DEV_ADDR && !byte_next[0]) begin
                                    state_reg <= ST_AACK; // RULE_01
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                state_reg <= ST_DACK;
                                if (byte_next[`ACW_REG_BIT]) begin // RULE_03
                                    setup_byte_reg <= byte_next; // RULE_04
                                    if (!byte_next[`ACW_RST_BIT]) begin
                                        configuration_byte_reg <= `ACW_CONFIG_RESET; // RULE_10
                                    end
                                end else begin
                                    configuration_byte_reg <= byte_next; // RULE_20
                                end
                            end
                        end
                    end
                end
                ST_AACK, ST_DACK: begin
                    // drive low after the eighth falling edge, release after the ninth
                    if (scl_fall) begin
                        if (!ack_hold_reg) begin
                            ack_hold_reg <= 1'b1;
                            o_sda_out <= 1'b0;
                            o_sda_oen_n <= 1'b0; // RULE_02 RULE_05
                        end else begin
                            ack_hold_reg <= 1'b0;
                            o_sda_oen_n <= 1'b1;
                            o_sda_out <= 1'b1;
                            state_reg <= ST_DATA;
                        end
                    end
                end
                ST_HNAK: begin
                    // not-acknowledge: leave sda released through the ninth clock
                    if (scl_fall) begin
                        if (!ack_hold_reg) begin
                            ack_hold_reg <= 1'b1;
                        end else begin
                            ack_hold_reg <= 1'b0;
                            o_hs_mode <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // field decode
    // ****************************************
    wire [3:0] cs_raw = configuration_byte_reg[`ACW_CS_HI:`ACW_CS_LO];
    reg [3:0] cs_eff;
    always @* begin
        cs_eff = cs_raw;
        if (CHAN_VARIANT == 2'd0) begin
            cs_eff = {2'b00, cs_raw[1:0]}; // RULE_12
        end else if (CHAN_VARIANT == 2'd1) begin
            cs_eff = {1'b0, cs_raw[2:0]}; // RULE_12
        end
    end
    wire sgl = configuration_byte_reg[`ACW_SGL_BIT];
    wire sel_mid = setup_byte_reg[`ACW_SEL_MID];
    wire shared_pin = (CHAN_VARIANT != 2'd1);
    wire [3:0] top_code = (CHAN_VARIANT == 2'd0) ? 4'h3 :
                          (CHAN_VARIANT == 2'd1) ? 4'h7 : `ACW_CODE_LIMIT;
    wire reserved = (cs_eff > `ACW_CODE_LIMIT); // RULE_14 RULE_18
    wire excluded = sgl & sel_mid & shared_pin & (cs_eff == top_code); // RULE_15
    wire [3:0] pair_base = {cs_eff[3:1], 1'b0};
    wire [11:0] one_hot = 12'h001 << cs_eff;
    wire [11:0] even_hot = 12'h001 << pair_base;
    wire [11:0] odd_hot = 12'h002 << pair_base;

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ref_sel <= 3'h0;
            o_clk_external <= 1'b0;
            o_bipolar <= 1'b0;
            o_sweep_sel <= 2'h0;
            o_chan_code <= 4'h0;
            o_single_ended <= 1'b1;
            o_pos_input <= 12'h001;
            o_neg_input <= 12'h000;
            o_neg_is_gnd <= 1'b1;
            o_code_reserved <= 1'b0;
            o_pin_excluded <= 1'b0;
            o_scan_limit <= 4'h0;
        end else begin
            o_ref_sel <= setup_byte_reg[`ACW_SEL_HI:`ACW_SEL_LO]; // RULE_08
            o_clk_external <= setup_byte_reg[`ACW_CLK_BIT]; // RULE_16
            // bit 0 of the setup byte is never looked at
            o_bipolar <= setup_byte_reg[`ACW_POL_BIT] & ~sgl; // RULE_09 RULE_17 RULE_11
            o_sweep_sel <= configuration_byte_reg[`ACW_SCAN_HI:`ACW_SCAN_LO]; // RULE_19
            o_chan_code <= cs_eff;
            o_single_ended <= sgl; // RULE_13
            o_code_reserved <= reserved;
            o_pin_excluded <= excluded;
            o_neg_is_gnd <= sgl;
            o_scan_limit <= excluded ? cs_eff - 4'h1 : cs_eff; // RULE_15
            if (reserved || excluded) begin
                o_pos_input <= 12'h000;
                o_neg_input <= 12'h000;
            end else if (sgl) begin
                o_pos_input <= one_hot; // RULE_14
                o_neg_input <= 12'h000;
            end else begin
                o_pos_input <= cs_eff[0] ? odd_hot : even_hot; // RULE_18
                o_neg_input <= cs_eff[0] ? even_hot : odd_hot;
            end
        end
    end
endmodule
`default_nettype wire

// ==== acw_defines.vh ====
// Contract
// RULE_01 - master sends start, address, write bit
// RULE_02 - acknowledge own address with write bit
// RULE_03 - msb one to setup, zero to configuration
// RULE_04 - accept one or two bytes, any order
// RULE_05 - acknowledge every received data byte
// RULE_06 - master ends with stop or repeated start
// RULE_07 - stop in high-speed mode restores fast mode
// RULE_08 - setup bits 6..4 reference select, reset zero
// RULE_09 - setup bit 2 polarity, default unipolar
// RULE_10 - setup bit 1 zero resets configuration
// RULE_11 - setup bit 0 ignored
// RULE_12 - channel code bits 4..1, variant forced zeros
// RULE_13 - config bit 0 input mode, default single
// RULE_14 - single-ended codes 0..11 select input, rest reserved
// RULE_15 - middle reference bit excludes shared pin; the code does so in single-ended mode only
// RULE_16 - setup bit 3 conversion clock, default internal
// RULE_17 - single-ended always converts unipolar
// RULE_18 - differential codes select pairs, lsb polarity
// RULE_19 - config bits 6..5 scan select, default zero
// RULE_20 - registers hold until overwritten or reset
`ifndef ACW_DEFINES_VH
`define ACW_DEFINES_VH
`define ACW_REG_BIT 7
`define ACW_SEL_HI 6
`define ACW_SEL_LO 4
`define ACW_SEL_MID 5
`define ACW_CLK_BIT 3
`define ACW_POL_BIT 2
`define ACW_RST_BIT 1
`define ACW_SCAN_HI 6
`define ACW_SCAN_LO 5
`define ACW_CS_HI 4
`define ACW_CS_LO 1
`define ACW_SGL_BIT 0
`define ACW_SETUP_RESET 8'h80
`define ACW_CONFIG_RESET 8'h01
`define ACW_HS_CODE 5'h01
`define ACW_CODE_LIMIT 4'hb
`endif

// ==== acw_master.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// bus master, 80 ns bit clock
// ****
module acw_master (
    input wire logic i_clk_sys,
    input wire logic i_sda_line,
    output var logic o_scl = 1'b1,
    output var logic o_sda = 1'b1
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic start_cond();
        o_sda <= 1'b1;
        tick(5);
        o_scl <= 1'b1;
        tick(8);
        o_sda <= 1'b0;
        tick(8);
        o_scl <= 1'b0;
        tick(5);
    endtask
    task automatic stop_cond();
        o_sda <= 1'b0;
        tick(5);
        o_scl <= 1'b1;
        tick(8);
        o_sda <= 1'b1;
        tick(8);
    endtask
    // scl high for only 6 cycles so a data bit never looks like idle
    task automatic send_byte(input logic [7:0] b, output logic acked);
        for (int i = 8; i >= 0; i--) begin
            o_sda <= (i > 0) ? b[i - 1] : 1'b1;
            tick(5);
            o_scl <= 1'b1;
            tick(3);
            acked = !i_sda_line;
            tick(3);
            o_scl <= 1'b0;
            tick(5);
        end
    endtask
endmodule
`default_nettype wire

// ==== acw_sync2.v ====
`timescale 1ns/100ps
`default_nettype none
module acw_sync2 #(
    parameter WIDTH = 2
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;
    // first stage is read only by the second stage
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= {WIDTH{1'b1}};
            o_sync <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== test_adc_setup_config_write.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// write-cycle bench
// ****
module test_adc_setup_config_write;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic ack;
    logic [7:0] setup_m = 8'h80, cfg_m = 8'h01, s, c;
    logic [31:0] lfsr = 32'h427d;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    wire scl, m_sda, sda_out, sda_oen_n, clk_ext, bipolar, sgl, neg_gnd, res, exc, hs;
    wire [2:0] ref_sel;
    wire [1:0] sweep;
    wire [3:0] code, scan_lim;
    wire [11:0] pos_in, neg_in;
    // a four-input device shares the bus and address so the forced code bits are exercised
    wire sda_out4, sda_oen4_n, exc4;
    wire [3:0] code4, scan4;
    wire [11:0] pos4;
    wire sda_line = m_sda & (sda_oen_n | sda_out) & (sda_oen4_n | sda_out4);
    acw_config_write #(.DEV_ADDR(7'h2a), .CHAN_VARIANT(2'd2)) i_acw_config_write (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oen_n(sda_oen_n), .o_ref_sel(ref_sel),
        .o_clk_external(clk_ext), .o_bipolar(bipolar), .o_sweep_sel(sweep), .o_chan_code(code),
        .o_single_ended(sgl), .o_pos_input(pos_in), .o_neg_input(neg_in), .o_neg_is_gnd(neg_gnd),
        .o_code_reserved(res), .o_pin_excluded(exc), .o_scan_limit(scan_lim), .o_hs_mode(hs));
    acw_config_write #(.DEV_ADDR(7'h2a), .CHAN_VARIANT(2'd0)) i_acw_config_write_four (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out4), .o_sda_oen_n(sda_oen4_n), .o_ref_sel(), .o_clk_external(),
        .o_bipolar(), .o_sweep_sel(), .o_chan_code(code4), .o_single_ended(),
        .o_pos_input(pos4), .o_neg_input(), .o_neg_is_gnd(), .o_code_reserved(),
        .o_pin_excluded(exc4), .o_scan_limit(scan4), .o_hs_mode());
    acw_master i_acw_master (.i_clk_sys(i_clk_sys), .i_sda_line(sda_line), .o_scl(scl),
        .o_sda(m_sda));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        logic [3:0] k, k4;
        logic r, x, x4;
        k = cfg_m[4:1];
        r = k > 4'hb;
        x = cfg_m[0] && setup_m[5] && k == 4'hb;
        k4 = {2'b00, k[1:0]};
        x4 = cfg_m[0] && setup_m[5] && k4 == 4'h3;
        check(scan_lim, x ? k - 4'h1 : k);
        check(code4, k4);
        check(exc4, x4);
        check(pos4, x4 ? 12'h000 : 12'h001 << k4);
        check(scan4, x4 ? k4 - 4'h1 : k4);
        check(ref_sel, setup_m[6:4]);
        check(clk_ext, setup_m[3]);
        check(bipolar, setup_m[2] & ~cfg_m[0]);
        check(sweep, cfg_m[6:5]);
        check(code, k);
        check({sgl, neg_gnd}, {2{cfg_m[0]}});
        check({res, exc}, {r, x});
        check(pos_in, (r || x) ? 12'h000 : 12'h001 << k);
        check(neg_in, (r || cfg_m[0]) ? 12'h000 : 12'h001 << (k ^ 4'h1));
    endtask
    task automatic xfer(input logic [7:0] a, b0, b1, input int n, input logic exp_ack);
        logic [7:0] b;
        i_acw_master.start_cond();
        i_acw_master.send_byte(a, ack);
        check(ack, exp_ack);
        for (int k = 0; k < n; k++) begin
            b = (k == 0) ? b0 : b1;
            i_acw_master.send_byte(b, ack);
            check(ack, exp_ack);
            if (exp_ack && b[7]) begin
                setup_m = b;
                cfg_m = b[1] ? cfg_m : 8'h01;
            end else if (exp_ack) begin
                cfg_m = b;
            end
        end
        i_acw_master.stop_cond();
        check_all();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        forever begin
            @(posedge i_clk_sys);
            cyc++;
            if (cyc > 60000) begin
                error_cnt++;
                tally_and_finish();
            end
        end
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        check_all();
        $display("reset defaults done");
        // codes and input modes from the loop count, one or two bytes in either order; a lone setup byte leaves some code and mode pairs unsent
        for (int i = 0; i < 48; i++) begin
            lfsr = lfsr_next(lfsr);
            s = {1'b1, lfsr[9:3]};
            c = {1'b0, lfsr[1:0], i[4:0]};
            xfer(8'h54, lfsr[10] ? s : c, lfsr[10] ? c : s, 1 + lfsr[11], 1'b1);
        end
        $display("write transfers done");
        xfer(8'h56, 8'h9e, 8'h3f, 2, 1'b0);
        xfer(8'h55, 8'h9e, 8'h3f, 1, 1'b0);
        $display("refused transfers done");
        i_acw_master.start_cond();
        i_acw_master.send_byte(8'h0b, ack);
        i_acw_master.tick(4);
        check({ack, hs}, 2'b01);
        xfer(8'h54, 8'hf4, 8'h17, 2, 1'b1);
        check(hs, 1'b0);
        $display("high-speed test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
